//--- ir_receive_capture_timer.sv
/*
  IR receive capture timer top. Synchronises the receive pin, qualifies
  edges, runs the 16-bit up counter and captures intervals, with a burst
  count mode for IR learning. Assumes software drives the control ports
  from the core clock and pulses the clear inputs to acknowledge flags.
*/
`timescale 1ns/1ps
module ir_receive_capture_timer
  import ir_rx_pkg::*;
(
  input  wire logic        CORE_CLK_IN,              // System clock, 20 MHz
  input  wire logic        RST_N_IN,                 // Asynchronous reset, low
  input  wire logic        IR_RECEIVE_PIN_IN,        // Raw receive pin
  input  wire logic        IR_DIRECTION_SELECT_IN,   // 0 receive, 1 transmit
  input  wire logic        IR_UNIT_ENABLE_IN,        // Unit enable
  input  wire logic [1:0]  RX_EDGE_SELECT_IN,        // Qualifying edges
  input  wire logic        COUNT_CLOCK_SELECT_IN,    // 0 carrier, 1 IR clock
  input  wire logic [1:0]  IR_CLOCK_DIV_IN,          // IR clock prescale exponent
  input  wire logic [15:0] CARRIER_PERIOD_REG_IN,    // High and low bytes
  input  wire logic        CAPTURE_RELOAD_ENABLE_IN, // Clear count on event
  input  wire logic        BURST_COUNT_ENABLE_IN,    // Burst count mode
  input  wire logic        IR_INTERRUPT_ENABLE_IN,   // Interrupt enable
  input  wire logic        EVENT_FLAG_CLEAR_IN,      // Pulse clears event flag
  input  wire logic        OVERFLOW_FLAG_CLEAR_IN,   // Pulse clears overflow flag
  output logic [15:0]      IR_COUNT_VALUE_OUT,       // Running count
  output logic [15:0]      IR_INTERVAL_REG_OUT,      // Capture or edge count
  output logic             IR_LEVEL_BIT_OUT,         // Level at last event
  output logic             IR_EVENT_FLAG_OUT,        // Sticky event flag
  output logic             IR_OVERFLOW_FLAG_OUT,     // Sticky overflow flag
  output logic             IR_IRQ_OUT,               // Interrupt request
  output logic             RX_ACTIVE_OUT             // Receive mode running
);
  // ----------------------------------------------------------------
  // Mode and timebase
  // ----------------------------------------------------------------
  logic rx_on;                                       // Receive mode active
  assign rx_on = IR_UNIT_ENABLE_IN && !IR_DIRECTION_SELECT_IN;

  ir_tick_if ticks ();                               // Timebase ticks

  ir_carrier_gen u_carrier (
    .clk_in                (CORE_CLK_IN),
    .rst_n_in              (RST_N_IN),
    .run_in                (rx_on),
    .div_in                (IR_CLOCK_DIV_IN),
    .carrier_period_reg_in (CARRIER_PERIOD_REG_IN),
    .ticks                 (ticks.source)
  );

  logic count_tick;                                  // Counter advance pulse
  assign count_tick = COUNT_CLOCK_SELECT_IN ? ticks.ir_clk_tick
                                            : ticks.carrier_tick;

  // ----------------------------------------------------------------
  // Pin synchroniser and edge qualification
  // ----------------------------------------------------------------
  logic sync1_reg;                                   // First stage, read by second only
  logic sync2_reg;                                   // Second stage
  logic prev_reg;                                    // Previous synced level

  // Two-stage synchroniser plus history
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= IR_RECEIVE_PIN_IN;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  logic rise;                                        // Rising edge seen
  logic fall;                                        // Falling edge seen
  logic qual;                                        // Qualified event
  logic prev_valid_reg;                              // History valid in receive mode
  assign rise = prev_valid_reg && sync2_reg && !prev_reg;
  assign fall = prev_valid_reg && !sync2_reg && prev_reg;

  // Edge select decode
  always_comb begin
    qual = 1'b0;
    if (rx_on) begin
      unique case (RX_EDGE_SELECT_IN)
        EDGE_FALL: qual = fall;
        EDGE_RISE: qual = rise;
        EDGE_BOTH: qual = rise || fall;
        EDGE_NONE: qual = 1'b0;
      endcase
    end
  end

  // History only valid after one receive-mode sample
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      prev_valid_reg <= 1'b0;
    end else begin
      prev_valid_reg <= rx_on;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic started_reg;                                 // First event seen
  logic wrap;                                        // Counter rolls over now
  assign wrap = started_reg && count_tick && (IR_COUNT_VALUE_OUT == COUNT_MAX);

  // Start latch: waits for the first qualified event
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      started_reg <= 1'b0;
    end else if (!rx_on) begin
      started_reg <= 1'b0;
    end else if (qual) begin
      started_reg <= 1'b1;
    end
  end

  // Up counter with optional reload on event
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IR_COUNT_VALUE_OUT <= COUNT_ZERO;
    end else if (!rx_on) begin
      IR_COUNT_VALUE_OUT <= COUNT_ZERO;
    end else if (!started_reg) begin
      IR_COUNT_VALUE_OUT <= COUNT_ZERO;
    end else if (qual && CAPTURE_RELOAD_ENABLE_IN) begin
      IR_COUNT_VALUE_OUT <= COUNT_ZERO;
    end else if (count_tick) begin
      IR_COUNT_VALUE_OUT <= IR_COUNT_VALUE_OUT + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Capture, level and burst count
  // ----------------------------------------------------------------
  logic burst_prev_reg;                              // Burst enable history
  logic burst_entry;                                 // Burst enable rose
  logic capture;                                     // Standard-mode capture
  assign burst_entry = BURST_COUNT_ENABLE_IN && !burst_prev_reg;
  assign capture     = qual && started_reg && !BURST_COUNT_ENABLE_IN;

  // Burst enable edge detect
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      burst_prev_reg <= 1'b0;
    end else begin
      burst_prev_reg <= BURST_COUNT_ENABLE_IN;
    end
  end

  // Interval register: capture or edge count
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IR_INTERVAL_REG_OUT <= INTERVAL_RST;
    end else if (burst_entry) begin
      IR_INTERVAL_REG_OUT <= BURST_START;
    end else if (BURST_COUNT_ENABLE_IN && qual) begin
      IR_INTERVAL_REG_OUT <= IR_INTERVAL_REG_OUT + 16'h0001;
    end else if (capture) begin
      IR_INTERVAL_REG_OUT <= IR_COUNT_VALUE_OUT;
    end
  end

  // Level bit follows the pin on later events
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IR_LEVEL_BIT_OUT <= 1'b0;
    end else if (qual && started_reg) begin
      IR_LEVEL_BIT_OUT <= rise;
    end
  end

  // ----------------------------------------------------------------
  // Space detector for burst mode
  // ----------------------------------------------------------------
  logic [1:0] idle_reg;                              // Carrier periods without edge
  logic       space_hit;                             // Space start detected
  assign space_hit = BURST_COUNT_ENABLE_IN && rx_on && !qual &&
                     ticks.carrier_tick && (idle_reg == SPACE_PERIODS - 2'h1);

  // Idle period counter, fires once per space
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      idle_reg <= 2'h0;
    end else if (!rx_on || !BURST_COUNT_ENABLE_IN || qual) begin
      idle_reg <= 2'h0;
    end else if (ticks.carrier_tick && idle_reg < SPACE_PERIODS) begin
      idle_reg <= idle_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  logic ev_set;                                      // Event flag set source
  assign ev_set = capture || space_hit;

  // Event flag, set wins over clear
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IR_EVENT_FLAG_OUT <= 1'b0;
    end else if (ev_set) begin
      IR_EVENT_FLAG_OUT <= 1'b1;
    end else if (EVENT_FLAG_CLEAR_IN) begin
      IR_EVENT_FLAG_OUT <= 1'b0;
    end
  end

  // Overflow flag, set wins over clear
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IR_OVERFLOW_FLAG_OUT <= 1'b0;
    end else if (wrap && !(qual && CAPTURE_RELOAD_ENABLE_IN)) begin
      IR_OVERFLOW_FLAG_OUT <= 1'b1;
    end else if (OVERFLOW_FLAG_CLEAR_IN) begin
      IR_OVERFLOW_FLAG_OUT <= 1'b0;
    end
  end

  // Interrupt request, registered from flags and enable
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IR_IRQ_OUT <= 1'b0;
    end else begin
      IR_IRQ_OUT <= IR_INTERRUPT_ENABLE_IN &&
                    (IR_EVENT_FLAG_OUT || IR_OVERFLOW_FLAG_OUT);
    end
  end

  // Receive-active status
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RX_ACTIVE_OUT <= 1'b0;
    end else begin
      RX_ACTIVE_OUT <= rx_on;
    end
  end
endmodule : ir_receive_capture_timer

//--- ir_rx_pkg.sv
/*
  Shared constants for the IR receive capture timer: widths, reset values,
  edge select encodings and the count values it loads.
  Assumes nothing of its surroundings beyond a single system clock.
*/
package ir_rx_pkg;
  localparam int CNT_W = 16;                        // Count and interval width
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;  // Counter start and reload value
  localparam logic [15:0] COUNT_MAX    = 16'hffff;  // Last value before wrap
  localparam logic [15:0] BURST_START  = 16'h0001;  // Interval value on burst entry
  localparam logic [15:0] INTERVAL_RST = 16'h0000;  // Interval reset value
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;     // Carrier phase counter reset
  localparam logic [1:0]  DIV_W        = 2'h2;      // Width of prescaler exponent
  localparam logic [1:0]  SPACE_PERIODS = 2'h2;     // Carrier periods marking a space
  // Edge select encodings
  localparam logic [1:0] EDGE_FALL = 2'h0;          // Falling edges only
  localparam logic [1:0] EDGE_RISE = 2'h1;          // Rising edges only
  localparam logic [1:0] EDGE_BOTH = 2'h2;          // Both edges
  localparam logic [1:0] EDGE_NONE = 2'h3;          // No capture events
  // Carrier phase
  typedef enum logic {PH_HIGH, PH_LOW} carrier_phase_e;
endpackage : ir_rx_pkg

//--- ir_tick_if.sv
/*
  Interface carrying the timebase ticks from the carrier generator to the
  capture logic. Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface ir_tick_if;
  logic ir_clk_tick;       // One pulse per prescaled IR clock
  logic carrier_tick;      // One pulse per complete carrier cycle
  modport source (output ir_clk_tick, output carrier_tick);
  modport sink   (input  ir_clk_tick, input  carrier_tick);
endinterface : ir_tick_if

//--- ir_carrier_gen.sv
/*
  Prescaler and carrier cycle generator. Emits an IR clock tick every
  2**div system clocks and a carrier tick at the end of each low portion.
  Assumes the carrier period word is stable from the core clock domain.
*/
`timescale 1ns/1ps
module ir_carrier_gen
  import ir_rx_pkg::*;
(
  input  wire logic        clk_in,          // System clock
  input  wire logic        rst_n_in,        // Asynchronous reset, low
  input  wire logic        run_in,          // Generator runs while high
  input  wire logic [1:0]  div_in,          // Prescaler exponent
  input  wire logic [15:0] carrier_period_reg_in, // High byte, low byte
  ir_tick_if.source        ticks
);
  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [2:0] pre_reg;                       // Free prescale counter
  logic       pre_hit;                       // Prescale terminal count
  logic [2:0] pre_mask;                      // Low bits that must be all ones

  assign pre_mask = 3'((4'h1 << div_in) - 4'h1);
  assign pre_hit  = ((pre_reg & pre_mask) == pre_mask);

  // Prescale counter, held clear while stopped
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_reg <= 3'h0;
    end else if (!run_in) begin
      pre_reg <= 3'h0;
    end else begin
      pre_reg <= pre_reg + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Carrier phases
  // ----------------------------------------------------------------
  carrier_phase_e phase_reg;                 // Current carrier portion
  logic [7:0]     phase_cnt_reg;             // IR clocks spent in portion
  logic [7:0]     phase_len;                 // Byte value of current portion
  logic [7:0]     carrier_high_count;        // High portion byte
  logic [7:0]     carrier_low_count;         // Low portion byte

  assign carrier_high_count = carrier_period_reg_in[15:8];
  assign carrier_low_count  = carrier_period_reg_in[7:0];
  assign phase_len = (phase_reg == PH_HIGH) ? carrier_high_count : carrier_low_count;

  // Each portion lasts its byte value plus one IR clocks
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg     <= PH_HIGH;
      phase_cnt_reg <= BYTE_ZERO;
    end else if (!run_in) begin
      phase_reg     <= PH_HIGH;
      phase_cnt_reg <= BYTE_ZERO;
    end else if (pre_hit) begin
      if (phase_cnt_reg == phase_len) begin  // Portion done
        phase_cnt_reg <= BYTE_ZERO;
        phase_reg     <= (phase_reg == PH_HIGH) ? PH_LOW : PH_HIGH;
      end else begin
        phase_cnt_reg <= phase_cnt_reg + 8'h1;
      end
    end
  end

  // Tick pulses, registered
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ticks.ir_clk_tick  <= 1'b0;
      ticks.carrier_tick <= 1'b0;
    end else begin
      ticks.ir_clk_tick  <= run_in && pre_hit;
      ticks.carrier_tick <= run_in && pre_hit && (phase_reg == PH_LOW) &&
                            (phase_cnt_reg == phase_len);
    end
  end
endmodule : ir_carrier_gen

//--- ir_rx_properties.sv
/*
  Checker for the IR receive capture timer, watching only top ports.
  Assumes one core clock and an asynchronous active low reset.
*/
`timescale 1ns/1ps
module ir_rx_properties
  import ir_rx_pkg::*;
(
  input  wire logic        CORE_CLK_IN,              // Core clock
  input  wire logic        RST_N_IN,                 // Reset, low
  input  wire logic        CAPTURE_RELOAD_ENABLE_IN, // Reload on event
  input  wire logic        BURST_COUNT_ENABLE_IN,    // Burst mode
  input  wire logic        IR_INTERRUPT_ENABLE_IN,   // Interrupt enable
  input  wire logic        EVENT_FLAG_CLEAR_IN,      // Event flag clear
  input  wire logic        OVERFLOW_FLAG_CLEAR_IN,   // Overflow flag clear
  input  wire logic [15:0] IR_COUNT_VALUE_OUT,       // Count
  input  wire logic [15:0] IR_INTERVAL_REG_OUT,      // Interval
  input  wire logic        IR_LEVEL_BIT_OUT,         // Level bit
  input  wire logic        IR_EVENT_FLAG_OUT,        // Event flag
  input  wire logic        IR_OVERFLOW_FLAG_OUT,     // Overflow flag
  input  wire logic        IR_IRQ_OUT,               // Interrupt request
  input  wire logic        RX_ACTIVE_OUT             // Receive running
);
  // ----------------------------------------
  // Helper and defaults
  // ----------------------------------------
  logic past_ok_reg; // High once a history edge exists
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Blocks $past from seeing reset-time inputs
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      past_ok_reg <= 1'b0;
    end else begin
      past_ok_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_irq; past_ok_reg |-> IR_IRQ_OUT ==
    $past(IR_INTERRUPT_ENABLE_IN && (IR_EVENT_FLAG_OUT || IR_OVERFLOW_FLAG_OUT)); endproperty
  a_irq: assert property (p_irq) else $error("irq not following flags");
  property p_ev_hold; IR_EVENT_FLAG_OUT && !EVENT_FLAG_CLEAR_IN |=> IR_EVENT_FLAG_OUT; endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("event flag dropped");
  property p_ov_hold;
    IR_OVERFLOW_FLAG_OUT && !OVERFLOW_FLAG_CLEAR_IN |=> IR_OVERFLOW_FLAG_OUT; endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overflow flag dropped");
  property p_ov_wrap; $rose(IR_OVERFLOW_FLAG_OUT) |-> $past(IR_COUNT_VALUE_OUT) == COUNT_MAX;
  endproperty
  a_ov_wrap: assert property (p_ov_wrap) else $error("overflow without wrap");
  property p_cnt_step; $changed(IR_COUNT_VALUE_OUT) |->
    IR_COUNT_VALUE_OUT == $past(IR_COUNT_VALUE_OUT) + 16'h0001 || IR_COUNT_VALUE_OUT == COUNT_ZERO;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count jumped");
  property p_capture;
    !BURST_COUNT_ENABLE_IN && !$past(BURST_COUNT_ENABLE_IN) && $changed(IR_INTERVAL_REG_OUT)
    |-> IR_EVENT_FLAG_OUT && IR_INTERVAL_REG_OUT == $past(IR_COUNT_VALUE_OUT)
    && (!$past(CAPTURE_RELOAD_ENABLE_IN) || IR_COUNT_VALUE_OUT == COUNT_ZERO); endproperty
  a_capture: assert property (p_capture) else $error("bad capture");
  property p_level; !BURST_COUNT_ENABLE_IN && !$past(BURST_COUNT_ENABLE_IN)
    && $changed(IR_LEVEL_BIT_OUT) |-> IR_EVENT_FLAG_OUT; endproperty
  a_level: assert property (p_level) else $error("level moved without event");
  property p_burst_entry; past_ok_reg && RX_ACTIVE_OUT && $rose(BURST_COUNT_ENABLE_IN)
    |=> IR_INTERVAL_REG_OUT == BURST_START; endproperty
  a_burst_entry: assert property (p_burst_entry) else $error("burst entry load");
  property p_burst_step; BURST_COUNT_ENABLE_IN && $past(BURST_COUNT_ENABLE_IN)
    && $past(BURST_COUNT_ENABLE_IN, 2) && $changed(IR_INTERVAL_REG_OUT)
    |-> IR_INTERVAL_REG_OUT == $past(IR_INTERVAL_REG_OUT) + 16'h0001
    && (!$past(CAPTURE_RELOAD_ENABLE_IN) || IR_COUNT_VALUE_OUT == COUNT_ZERO); endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst step");
  property p_idle; !RX_ACTIVE_OUT && $past(!RX_ACTIVE_OUT) |-> IR_COUNT_VALUE_OUT == COUNT_ZERO;
  endproperty
  a_idle: assert property (p_idle) else $error("count moving while stopped");
endmodule : ir_rx_properties
bind ir_receive_capture_timer ir_rx_properties u_props (.CORE_CLK_IN(CORE_CLK_IN),
  .RST_N_IN(RST_N_IN), .CAPTURE_RELOAD_ENABLE_IN(CAPTURE_RELOAD_ENABLE_IN),
  .BURST_COUNT_ENABLE_IN(BURST_COUNT_ENABLE_IN), .IR_INTERRUPT_ENABLE_IN(IR_INTERRUPT_ENABLE_IN),
  .EVENT_FLAG_CLEAR_IN(EVENT_FLAG_CLEAR_IN), .OVERFLOW_FLAG_CLEAR_IN(OVERFLOW_FLAG_CLEAR_IN),
  .IR_COUNT_VALUE_OUT(IR_COUNT_VALUE_OUT), .IR_INTERVAL_REG_OUT(IR_INTERVAL_REG_OUT),
  .IR_LEVEL_BIT_OUT(IR_LEVEL_BIT_OUT), .IR_EVENT_FLAG_OUT(IR_EVENT_FLAG_OUT),
  .IR_OVERFLOW_FLAG_OUT(IR_OVERFLOW_FLAG_OUT), .IR_IRQ_OUT(IR_IRQ_OUT),
  .RX_ACTIVE_OUT(RX_ACTIVE_OUT));

//--- ir_rx_source.sv
/*
  Infrared receiver model: on go, sends pulses of low then high halves.
  Assumes the pin idles high through its pull-up between bursts.
*/
`timescale 1ns/1ps
module ir_rx_source (
  input  wire logic       clk_in,    // Core clock
  input  wire logic       rst_n_in,  // Reset, low
  input  wire logic       go_in,     // Start a burst
  input  wire logic [7:0] half_in,   // Clocks per half pulse
  input  wire logic [7:0] pulses_in, // Pulses per burst
  output logic            pin_out,   // Receiver output
  output logic            busy_out   // Burst in progress
);
  logic [7:0] tick_reg; // Clocks left in this half
  logic [8:0] left_reg; // Halves left in burst
  // Toggle the line every half; idle level high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left_reg <= 9'h000;
      tick_reg <= 8'h00;
      pin_out  <= 1'b1;
    end else if (go_in && left_reg == 9'h000) begin
      left_reg <= {pulses_in, 1'b0};
      tick_reg <= half_in;
      pin_out  <= 1'b0;
    end else if (left_reg != 9'h000) begin
      if (tick_reg > 8'h01) begin
        tick_reg <= tick_reg - 8'h01;
      end else begin
        tick_reg <= half_in;
        left_reg <= left_reg - 9'h001;
        pin_out  <= (left_reg == 9'h001) ? 1'b1 : ~pin_out;
      end
    end
  end
  assign busy_out = (left_reg != 9'h000);
endmodule : ir_rx_source

//--- test_ir_receive_capture_timer.sv
/*
  Self-checking bench for the IR receive capture timer.
  Assumes the receiver model drives the pin and the checker is bound.
*/
`timescale 1ns/1ps
module test_ir_receive_capture_timer;
  import ir_rx_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk = 1'b0, rst_n = 1'b0, dir = 1'b0, en = 1'b0; // Clock, reset, mode
  logic        ccs = 1'b1, rl = 1'b1, bm = 1'b0, ie = 1'b1;     // Timebase, reload, burst, irq
  logic        ecl = 1'b0, ocl = 1'b0, go = 1'b0;               // Clears, model start
  logic [1:0]  sel = EDGE_FALL, div = 2'h0;                      // Edges, prescale
  logic [7:0]  half = 8'h04, npul = 8'h01;                       // Model shape
  logic [15:0] cper = 16'h0102;                                  // High 1, low 2
  logic [15:0] cnt, ivl;                                         // Count, interval
  logic        lvl, evf, ovf, irq, act, pin, busy, c;            // Outputs, scratch
  logic [1:0]  dv;                                               // Chosen prescale
  logic [31:0] seed = 32'h6594c142;                              // Random state
  int          n_mismatch = 0, checks_done = 0, cycles = 0, d, g, p, k;
  always #25 clk = ~clk;
  ir_receive_capture_timer uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .IR_RECEIVE_PIN_IN(pin),
    .IR_DIRECTION_SELECT_IN(dir), .IR_UNIT_ENABLE_IN(en), .RX_EDGE_SELECT_IN(sel),
    .COUNT_CLOCK_SELECT_IN(ccs), .IR_CLOCK_DIV_IN(div), .CARRIER_PERIOD_REG_IN(cper),
    .CAPTURE_RELOAD_ENABLE_IN(rl), .BURST_COUNT_ENABLE_IN(bm), .IR_INTERRUPT_ENABLE_IN(ie),
    .EVENT_FLAG_CLEAR_IN(ecl), .OVERFLOW_FLAG_CLEAR_IN(ocl), .IR_COUNT_VALUE_OUT(cnt),
    .IR_INTERVAL_REG_OUT(ivl), .IR_LEVEL_BIT_OUT(lvl), .IR_EVENT_FLAG_OUT(evf),
    .IR_OVERFLOW_FLAG_OUT(ovf), .IR_IRQ_OUT(irq), .RX_ACTIVE_OUT(act));
  ir_rx_source u_src (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .half_in(half),
    .pulses_in(npul), .pin_out(pin), .busy_out(busy));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s); // Xorshift step
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic int per(input logic cs, input logic [1:0] e); // Clocks per count
    return (cs ? 1 : int'(cper[15:8]) + int'(cper[7:0]) + 2) << e;
  endfunction : per
  task automatic tick(input int n); repeat (n) @(posedge clk); endtask : tick
  task automatic look(input int n); tick(n); #1; endtask : look
  task automatic chk(input logic [15:0] got, input logic [15:0] exp); // Exact value
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi); // Window
    checks_done++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic restart; // Stop and restart receive, clearing flags
    tick(1);
    en  <= 1'b0;
    ecl <= 1'b1;
    ocl <= 1'b1;
    tick(2);
    en  <= 1'b1;
    ecl <= 1'b0;
    ocl <= 1'b0;
    tick(2);
  endtask : restart
  task automatic send(input logic [7:0] h, input logic [7:0] n); // One model burst
    tick(1);
    half <= h;
    npul <= n;
    go   <= 1'b1;
    tick(1);
    go   <= 1'b0;
    tick(1);
    for (int w = 0; w < 4000 && busy !== 1'b0; w++) tick(1);
  endtask : send
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // Hang guard, well above the overflow wait
  always @(posedge clk) begin
    cycles++;
    if (cycles > 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    tick(8);
    rst_n <= 1'b1;
    restart();
    look(1);
    chk(act, 1'b1);
    // Every edge select with random gap, timebase and prescale
    for (int s = 0; s < 4; s++) begin
      seed = xs(seed);
      d    = 30 + int'(seed[5:0]);
      c    = seed[8];
      dv   = seed[9] ? 2'h2 : 2'h0;
      g    = (s == 2) ? d : 2 * d;
      p    = per(c, dv);
      tick(1);
      sel <= 2'(s);
      ccs <= c;
      div <= dv;
      restart();
      send(8'(d), 8'h02);
      look(6);
      chk(evf, s != 3);
      chk(lvl, s != 0);
      chk(irq, s != 3);
      if (s != 3) chk_rng(ivl, g / p - 1, g / p + 1);
    end
    // Free running count across several captures
    tick(1);
    sel <= EDGE_BOTH;
    ccs <= 1'b1;
    div <= 2'h0;
    rl  <= 1'b0;
    restart();
    seed = xs(seed);
    d    = 30 + int'(seed[5:0]);
    send(8'(d), 8'h02);
    look(4);
    chk_rng(ivl, 3 * d - 1, 3 * d + 1);
    // Wrap with interrupt masked, then unmasked, then cleared
    tick(1);
    ie  <= 1'b0;
    ecl <= 1'b1;
    tick(1);
    ecl <= 1'b0;
    look(65600);
    chk(ovf, 1'b1);
    chk(irq, 1'b0);
    tick(1);
    ie <= 1'b1;
    look(3);
    chk(irq, 1'b1);
    tick(1);
    ocl <= 1'b1;
    tick(1);
    ocl <= 1'b0;
    look(3);
    chk(ovf, 1'b0);
    chk(irq, 1'b0);
    // Burst count of a random carrier burst, then a space
    tick(1);
    ccs <= 1'b0;
    rl  <= 1'b1;
    restart();
    bm <= 1'b1;
    look(2);
    chk(ivl, BURST_START);
    tick(12);
    ecl <= 1'b1;
    tick(1);
    ecl <= 1'b0;
    seed = xs(seed);
    k    = 3 + int'(seed[2:0]);
    send(8'h03, 8'(k));
    look(2);
    chk(ivl, 16'(1 + 2 * k));
    chk(evf, 1'b0);
    look(30);
    chk(evf, 1'b1);
    // Transmit direction stops receive and ignores edges
    tick(1);
    dir <= 1'b1;
    bm  <= 1'b0;
    ecl <= 1'b1;
    tick(1);
    ecl <= 1'b0;
    send(8'h0a, 8'h02);
    look(5);
    chk(act, 1'b0);
    chk(cnt, COUNT_ZERO);
    chk(evf, 1'b0);
    wrap_up();
  end
endmodule : test_ir_receive_capture_timer
